// ---- rtl/ebt_timer.v ----
// Eight-bit interval / PWM timer with carrier output control and port direction register
// Summary of operation
// - Remote output low if buffer bit 0; else high, or carrier when remote enabled.
// - Carrier status flag in bit 0 is read-only; shows carrier output enable.
// - Reset clears carrier control register; byte and single-bit writes both work.
// - Direction bit 0 drives pin, 1 floats it; reset sets all ones.
// - Interval mode: counter match with cycle compare raises interrupt, clears counter.
// - Interval mode ignores duty compare completely.
// - Interval mode with output enabled toggles output each match: 50% square wave.
// - Counting begins within one count clock of setting run enable in interval mode, within two in PWM mode.
// - Clearing run enable forces interrupt and output inactive; inactive ones stay.
// - New duty value takes effect at the first old duty match after three count clocks; at once while stopped.
// - PWM first compares cycle; match clears counter, interrupts, output active, to duty.
// - PWM duty match makes output inactive, back to cycle; no clear, no interrupt.
// - Period is N+1 count clocks, active width M+1 count clocks.
// - PWM start masks one count clock; output inactive until first cycle match.
// - Default level bit sets inactive output polarity: 0 low, 1 high.
// - Run enable clear stops and zeroes counter; set starts counting.
`include "ebt_defines.vh"
module ebt_timer #(
  parameter DW = 8
) (
  input wire CLK,
  input wire RSTN,
  input wire [`EBT_ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire CARRIER_PULSE,
  input wire CARRIER_XFER,
  output reg TIMER_MATCH_IRQ,
  output wire TIMER_WAVE_OUTPUT,
  output wire REMOTE_OUTPUT,
  output wire [7:0] PORT_OUT,
  output wire [7:0] PORT_OE
);
  // ****************************************************************
  // Register bank
  // ****************************************************************
  localparam [DW-1:0] ONE = {{(DW-1){1'b0}}, 1'b1};
  reg [7:0] port_one_direction_q;
  reg [7:0] port_latch_q;
  reg [7:0] timer_mode_register_q;
  reg [2:1] carrier_ctl_q;
  reg carrier_status_flag_q;
  reg [DW-1:0] cycle_compare_q;
  reg [DW-1:0] duty_pending_q;
  reg [DW-1:0] duty_compare_q;
  reg [7:0] div_q;
  reg [1:0] xfer_age_q;
  reg xfer_pend_q;

  function sel;
    input [`EBT_ADDR_W-1:0] a;
    input [`EBT_ADDR_W-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  wire run_enable = timer_mode_register_q[`EBT_MODE_RUN];
  wire [1:0] mode = timer_mode_register_q[`EBT_MODE_MD_HI:`EBT_MODE_MD_LO];
  wire pwm_mode = (mode == `EBT_MD_PWM);
  wire output_enable = timer_mode_register_q[`EBT_MODE_OEN];
  wire output_default_level = timer_mode_register_q[`EBT_MODE_LEV];
  wire wr_duty = WR && sel(ADDR, `EBT_OFS_DUTY_CMP);
  wire tick;

  // Address decode shared by the write and read sides
  wire sel_dir = sel(ADDR, `EBT_OFS_PORT_DIR);
  wire sel_latch = sel(ADDR, `EBT_OFS_PORT_LATCH);
  wire sel_mode = sel(ADDR, `EBT_OFS_MODE);
  wire sel_car = sel(ADDR, `EBT_OFS_CARRIER);
  wire sel_cyc = sel(ADDR, `EBT_OFS_CYCLE_CMP);
  wire sel_duty = sel(ADDR, `EBT_OFS_DUTY_CMP);
  wire sel_cnt = sel(ADDR, `EBT_OFS_COUNT);
  wire sel_div = sel(ADDR, `EBT_OFS_DIV);

  // Divider register stands in for a count clock selector
  ebt_count_tick #(.W(8)) ebt_count_tick_i (
    .clk(CLK),
    .rst_n(RSTN),
    .run(run_enable),
    .div(div_q),
    .tick(tick)
  );

  // ****************************************************************
  // Port registers
  // ****************************************************************
  // Pins leave reset as inputs so nothing is driven before setup
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      port_one_direction_q <= `EBT_RST_PORT_DIR;
    end else if (WR && sel_dir) begin
      port_one_direction_q <= WDATA;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      port_latch_q <= `EBT_RST_PORT_LATCH;
    end else if (WR && sel_latch) begin
      port_latch_q <= WDATA;
    end
  end

  // ****************************************************************
  // Timer control registers
  // ****************************************************************
  // Mode bits are only safe to change while stopped; nothing here guards it
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      timer_mode_register_q <= `EBT_RST_MODE;
    end else if (WR && sel_mode) begin
      timer_mode_register_q <= WDATA;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cycle_compare_q <= {DW{1'b0}};
    end else if (WR && sel_cyc) begin
      cycle_compare_q <= WDATA[DW-1:0];
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_q <= `EBT_RST_DIV;
    end else if (WR && sel_div) begin
      div_q <= WDATA;
    end
  end

  // ****************************************************************
  // Carrier control register
  // ****************************************************************
  // Only the two writable bits live here; the status flag is a
  // separate flop fed by the transfer strobe
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      carrier_ctl_q <= 2'h0;
    end else if (WR && sel_car) begin
      // Status bit ignores writes; bit writes arrive as read-modify-write bytes
      carrier_ctl_q <= WDATA[2:1];
    end
  end

  // Status flag follows buffer bit on the transfer strobe
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      carrier_status_flag_q <= 1'b0;
    end else if (CARRIER_XFER) begin
      carrier_status_flag_q <= carrier_ctl_q[`EBT_CAR_BUFFER];
    end
  end

  // ****************************************************************
  // Duty compare transfer
  // ****************************************************************
  // Written value waits in a latch while running; it moves to the live compare only
  // after three count clocks and at an idle point of the waveform.
  reg duty_phase_q;
  reg [DW-1:0] counter_q;
  wire duty_hit = tick && duty_phase_q && (counter_q == duty_compare_q);
  // Pending duty value has waited long enough to be taken over
  wire xfer_ready = (xfer_age_q == `EBT_DUTY_XFER_CLKS);

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      duty_pending_q <= {DW{1'b0}};
      duty_compare_q <= {DW{1'b0}};
      xfer_age_q <= 2'h0;
      xfer_pend_q <= 1'b0;
    end else if (wr_duty) begin
      duty_pending_q <= WDATA[DW-1:0];
      xfer_age_q <= 2'h0;
      xfer_pend_q <= 1'b1;
      // A stopped timer has no waveform to protect, so load at once
      if (!run_enable) begin
        duty_compare_q <= WDATA[DW-1:0];
        xfer_pend_q <= 1'b0;
      end
    end else if (xfer_pend_q && tick) begin
      if (!xfer_ready) begin
        xfer_age_q <= xfer_age_q + 2'h1;
      end
      // Transfer at the old duty match, once three count clocks are past
      if (duty_hit && xfer_ready) begin
        duty_compare_q <= duty_pending_q;
        xfer_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Counter and compare sequencing
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_MASK = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  reg [2:0] state_q;
  reg wave_q;
  // Interval mode never leaves the cycle phase
  wire cycle_hit = tick && !duty_phase_q && (counter_q == cycle_compare_q);

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      counter_q <= {DW{1'b0}};
      duty_phase_q <= 1'b0;
      wave_q <= 1'b0;
      TIMER_MATCH_IRQ <= 1'b0;
    end else begin
      // Interrupt is a one-cycle pulse
      TIMER_MATCH_IRQ <= 1'b0;
      // Idle holds everything cleared so a restart always begins from zero
      case (state_q)
        ST_IDLE: begin
          counter_q <= {DW{1'b0}};
          duty_phase_q <= 1'b0;
          wave_q <= 1'b0;
          if (run_enable) begin
            state_q <= pwm_mode ? ST_MASK : ST_RUN;
          end
        end
        ST_MASK: begin
          // First count clock after enable is swallowed in PWM mode
          if (!run_enable) begin
            state_q <= ST_IDLE;
          end else if (tick) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!run_enable) begin
            state_q <= ST_IDLE;
            counter_q <= {DW{1'b0}};
            wave_q <= 1'b0;
          end else if (cycle_hit) begin
            counter_q <= {DW{1'b0}};
            TIMER_MATCH_IRQ <= 1'b1;
            if (pwm_mode) begin
              wave_q <= 1'b1;
              duty_phase_q <= 1'b1;
            end else begin
              wave_q <= ~wave_q;
            end
          end else if (duty_hit && pwm_mode) begin
            // Only PWM looks at duty compare; interval never enters duty phase
            wave_q <= 1'b0;
            duty_phase_q <= 1'b0;
            counter_q <= counter_q + ONE;
          end else if (tick) begin
            counter_q <= counter_q + ONE;
          end
        end
        default: begin
          // Illegal state code: fall back to idle with the outputs quiet
          state_q <= ST_IDLE;
          counter_q <= {DW{1'b0}};
          duty_phase_q <= 1'b0;
          wave_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output and pin drive
  // ****************************************************************
  // Active level is the inverse of the default level
  assign TIMER_WAVE_OUTPUT = output_enable ? (wave_q ^ output_default_level)
                                           : output_default_level;

  // Remote output: buffer off forces low, remote off gives a steady high
  reg remote_d;
  always @* begin
    remote_d = 1'b0;
    case (carrier_ctl_q)
      2'b01: remote_d = 1'b1;
      2'b11: remote_d = CARRIER_PULSE;
      default: remote_d = 1'b0;
    endcase
  end
  assign REMOTE_OUTPUT = remote_d;

  // ****************************************************************
  // Port pin drive
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      // Timer pin shows the wave only when the latch is cleared too
      if (gi == `EBT_TIMER_PIN) begin : g_tmr
        assign PORT_OUT[gi] = port_latch_q[gi] | TIMER_WAVE_OUTPUT;
      end else begin : g_gpio
        assign PORT_OUT[gi] = port_latch_q[gi];
      end
      assign PORT_OE[gi] = ~port_one_direction_q[gi];
    end
  endgenerate

  // ****************************************************************
  // Read port
  // ****************************************************************
  reg [7:0] rd_mux_d;

  // Unmapped addresses read as zero
  always @* begin
    rd_mux_d = 8'h00;
    if (sel_dir) begin
      rd_mux_d = port_one_direction_q;
    end else if (sel_latch) begin
      rd_mux_d = port_latch_q;
    end else if (sel_mode) begin
      rd_mux_d = timer_mode_register_q;
    end else if (sel_car) begin
      rd_mux_d = {5'h00, carrier_ctl_q, carrier_status_flag_q};
    end else if (sel_cyc) begin
      rd_mux_d = cycle_compare_q;
    end else if (sel_duty) begin
      // Software sees the value last written, not the live compare
      rd_mux_d = duty_pending_q;
    end else if (sel_cnt) begin
      rd_mux_d = counter_q;
    end else if (sel_div) begin
      rd_mux_d = div_q;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rd_mux_d;
    end
  end
endmodule

// ---- pkg/ebt_defines.vh ----
// Register map, field positions, reset values and mode codes of the interval/PWM timer
`ifndef EBT_DEFINES_VH
`define EBT_DEFINES_VH
`define EBT_ADDR_W 16
`define EBT_OFS_PORT_DIR 16'hFF21
`define EBT_OFS_PORT_LATCH 16'hFF01
`define EBT_OFS_MODE 16'hFF6C
`define EBT_OFS_CARRIER 16'hFF6D
`define EBT_OFS_CYCLE_CMP 16'hFF0E
`define EBT_OFS_DUTY_CMP 16'hFF0F
`define EBT_OFS_COUNT 16'hFF10
`define EBT_OFS_DIV 16'hFF11
`define EBT_RST_PORT_DIR 8'hFF
`define EBT_RST_PORT_LATCH 8'h00
`define EBT_RST_MODE 8'h00
`define EBT_RST_CARRIER 8'h00
`define EBT_RST_CMP 8'h00
`define EBT_RST_DIV 8'h00
`define EBT_MODE_RUN 7
`define EBT_MODE_MD_HI 3
`define EBT_MODE_MD_LO 2
`define EBT_MODE_LEV 1
`define EBT_MODE_OEN 0
`define EBT_MD_INTERVAL 2'h0
`define EBT_MD_PWM 2'h2
`define EBT_CAR_REMOTE 2
`define EBT_CAR_BUFFER 1
`define EBT_CAR_STATUS 0
`define EBT_CAR_WMASK 8'h06
`define EBT_DUTY_XFER_CLKS 2'h3
`define EBT_TIMER_PIN 6
`endif

// ---- rtl/ebt_count_tick.v ----
// Count clock enable divider for the interval/PWM timer
module ebt_count_tick #(
  parameter W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire [W-1:0] div,
  output reg tick
);
  reg [W-1:0] cnt_q;

  // Divider restarts at run so the first tick comes at most div+1 clocks later
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule

// ---- sim/ebt_timer_properties.sv ----
// Port-level assertions for the interval/PWM timer
`include "ebt_defines.vh"
module ebt_timer_props (
  input wire CLK,
  input wire RSTN,
  input wire [15:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire CARRIER_PULSE,
  input wire TIMER_MATCH_IRQ,
  input wire TIMER_WAVE_OUTPUT,
  input wire REMOTE_OUTPUT,
  input wire [7:0] PORT_OE
);
  // Shadows of the mode, carrier and direction registers, rebuilt from bus traffic
  logic [7:0] mode_q;
  logic [7:0] car_q;
  logic [7:0] dir_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_q <= 8'h00;
      car_q <= 8'h00;
      dir_q <= 8'hFF;
    end else if (WR) begin
      if (ADDR == `EBT_OFS_MODE) mode_q <= WDATA;
      if (ADDR == `EBT_OFS_CARRIER) car_q <= WDATA & `EBT_CAR_WMASK;
      if (ADDR == `EBT_OFS_PORT_DIR) dir_q <= WDATA;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence stopped_s;
    !mode_q[7] ##1 !mode_q[7];
  endsequence
  irq_needs_run_a: assert property (
    TIMER_MATCH_IRQ |-> $past(mode_q[7])) else $error("irq while stopped");
  stop_quiet_a: assert property (stopped_s |->
    !TIMER_MATCH_IRQ && TIMER_WAVE_OUTPUT == mode_q[1]) else $error("stop not quiet");
  out_default_a: assert property (
    !mode_q[0] |-> TIMER_WAVE_OUTPUT == mode_q[1]) else $error("disabled output level");
  remote_gate_a: assert property (
    REMOTE_OUTPUT == (car_q[1] & (~car_q[2] | CARRIER_PULSE))) else $error("remote level");
  dir_oe_a: assert property (PORT_OE == ~dir_q) else $error("pin enable");
  carrier_read_a: assert property (RD && ADDR == `EBT_OFS_CARRIER |=>
    RDATA[7:1] == {5'h00, car_q[2:1]}) else $error("carrier readback");
  wave_toggle_a: assert property ($rose(TIMER_MATCH_IRQ) && mode_q[0] &&
    mode_q[3:2] == `EBT_MD_INTERVAL |-> TIMER_WAVE_OUTPUT != $past(TIMER_WAVE_OUTPUT, 2))
    else $error("no toggle on match");
  pwm_active_a: assert property ($rose(TIMER_MATCH_IRQ) && mode_q[0] &&
    mode_q[3:2] == `EBT_MD_PWM |-> TIMER_WAVE_OUTPUT != mode_q[1] ||
    $past(TIMER_WAVE_OUTPUT) != mode_q[1]) else $error("pwm not active on match");
endmodule
bind ebt_timer ebt_timer_props ebt_timer_props_i (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .CARRIER_PULSE, .TIMER_MATCH_IRQ, .TIMER_WAVE_OUTPUT, .REMOTE_OUTPUT, .PORT_OE);

// ---- sim/ebt_load.sv ----
// Load on the timer pin: measures period, high width and interrupt spacing
module ebt_load (
  input wire clk,
  input wire pin,
  input wire irq,
  output logic [15:0] period = 16'h0000,
  output logic [15:0] high_w = 16'h0000,
  output logic [15:0] irq_gap = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] pc = 16'h0000;
  logic [15:0] hc = 16'h0000;
  logic [15:0] ic = 16'h0000;
  logic pin_q = 1'b1;
  always @(posedge clk) begin
    pin_q <= pin;
    pc <= (pin && !pin_q) ? 16'h0001 : pc + 16'h0001;
    if (pin && !pin_q) period <= pc;
    hc <= pin ? hc + 16'h0001 : 16'h0000;
    if (!pin && pin_q) high_w <= hc;
    ic <= irq ? 16'h0001 : ic + 16'h0001;
    if (irq) irq_gap <= ic;
  end
endmodule

// ---- sim/test_ebt_timer.sv ----
// Self-checking bench for the interval/PWM timer
`include "ebt_defines.vh"
module test_ebt_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0;
  logic CARRIER_PULSE = 1'b0, CARRIER_XFER = 1'b0;
  logic [15:0] ADDR = 16'h0000;
  logic [7:0] WDATA = 8'h00;
  wire [7:0] RDATA, PORT_OUT, PORT_OE;
  wire TIMER_MATCH_IRQ, TIMER_WAVE_OUTPUT, REMOTE_OUTPUT, pin;
  wire [15:0] period, high_w, irq_gap;
  int bad_count = 0;
  int n_tests = 0;
  always #5 CLK = ~CLK;
  // Pull-up on the pin while its buffer is off
  assign pin = PORT_OE[`EBT_TIMER_PIN] ? PORT_OUT[`EBT_TIMER_PIN] : 1'b1;
  ebt_timer ebt_timer_i (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CARRIER_PULSE(CARRIER_PULSE), .CARRIER_XFER(CARRIER_XFER),
    .TIMER_MATCH_IRQ(TIMER_MATCH_IRQ), .TIMER_WAVE_OUTPUT(TIMER_WAVE_OUTPUT),
    .REMOTE_OUTPUT(REMOTE_OUTPUT), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE));
  ebt_load ebt_load_i (.clk(CLK), .pin(pin), .irq(TIMER_MATCH_IRQ), .period(period),
    .high_w(high_w), .irq_gap(irq_gap));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    chk({8'h00, RDATA}, {8'h00, exp});
  endtask
  task settle(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask
  task close_out;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    rd(`EBT_OFS_CARRIER, 8'h00);
    rd(`EBT_OFS_PORT_DIR, 8'hFF);
    rd(16'hFF00, 8'h00);
    wr(`EBT_OFS_CARRIER, 8'hFF);
    rd(`EBT_OFS_CARRIER, 8'h06);
    @(posedge CLK) CARRIER_XFER <= 1'b1;
    @(posedge CLK) CARRIER_XFER <= 1'b0;
    rd(`EBT_OFS_CARRIER, 8'h07);
    for (int i = 0; i < 8; i++) begin
      wr(`EBT_OFS_CARRIER, {5'h00, i[1:0], 1'b0});
      @(posedge CLK) CARRIER_PULSE <= i[2];
      settle(1);
      chk({15'h0000, REMOTE_OUTPUT}, {15'h0000, i[0] & (~i[1] | i[2])});
    end
    wr(`EBT_OFS_PORT_LATCH, 8'h00);
    wr(`EBT_OFS_PORT_DIR, 8'hBF);
    settle(1);
    chk({8'h00, PORT_OE}, 16'h0040);
    // Interval, square wave, default level high
    wr(`EBT_OFS_DIV, 8'h00);
    wr(`EBT_OFS_CYCLE_CMP, 8'h03);
    wr(`EBT_OFS_MODE, 8'h83);
    wr(`EBT_OFS_DUTY_CMP, 8'h01);
    settle(60);
    chk(irq_gap, 16'h0004);
    chk(period, 16'h0008);
    chk(high_w, 16'h0004);
    wr(`EBT_OFS_MODE, 8'h03);
    settle(2);
    chk({15'h0000, TIMER_MATCH_IRQ}, 16'h0000);
    chk({15'h0000, TIMER_WAVE_OUTPUT}, 16'h0001);
    chk({8'h00, PORT_OUT}, 16'h0040);
    rd(`EBT_OFS_COUNT, 8'h00);
    // PWM on a count clock of every second cycle
    wr(`EBT_OFS_MODE, 8'h08);
    wr(`EBT_OFS_DIV, 8'h01);
    wr(`EBT_OFS_CYCLE_CMP, 8'h05);
    wr(`EBT_OFS_DUTY_CMP, 8'h02);
    wr(`EBT_OFS_MODE, 8'h89);
    settle(80);
    chk(period, 16'h000C);
    chk(high_w, 16'h0006);
    chk(irq_gap, 16'h000C);
    wr(`EBT_OFS_DUTY_CMP, 8'h00);
    settle(80);
    chk(high_w, 16'h0002);
    chk(period, 16'h000C);
    wr(`EBT_OFS_MODE, 8'h09);
    close_out;
  end
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
endmodule
